// ===== hw/icx_pkg.sv
// icx_pkg: register map, field layout and state carrier of the interrupt controller
package icx_pkg;

  // ********************************************************
  // register offsets
  // ********************************************************
  localparam logic [15:0] ADDR_PIN_FUNCTION = 16'h0000;
  localparam logic [15:0] ADDR_PIN_PULL_ENABLE = 16'h0008;
  localparam logic [15:0] ADDR_PIN_INPUT_ENABLE = 16'h000c;
  localparam logic [15:0] ADDR_PIN_INPUT_VALUE = 16'h0010;
  localparam logic [15:0] ADDR_EXT_IRQ_CONFIG_A = 16'h0a20;
  localparam logic [15:0] ADDR_EXT_IRQ_CONFIG_B = 16'h0a24;
  localparam logic [15:0] ADDR_EXT_IRQ_CONFIG_C = 16'h0a28;
  localparam logic [15:0] ADDR_EXT_IRQ_CLEAR = 16'h0a30;
  localparam logic [15:0] ADDR_CUSTOM_IRQ_TRIGGER = 16'h209c;
  localparam logic [15:0] ADDR_IRQ_POLARITY = 16'h3000;
  localparam logic [15:0] ADDR_IRQ_CLEAR = 16'h3004;
  localparam logic [15:0] ADDR_IRQ_SOURCE_SELECT_A = 16'h3008;
  localparam logic [15:0] ADDR_IRQ_SOURCE_SELECT_B = 16'h300c;
  localparam logic [15:0] ADDR_IRQ_FLAG_A = 16'h3010;
  localparam logic [15:0] ADDR_IRQ_FLAG_B = 16'h3014;

  // ********************************************************
  // reset values
  // ********************************************************
  localparam logic [31:0] RST_SOURCE_SELECT = 32'h0000_2000;
  localparam logic [31:0] RST_CUSTOM_TRIGGER = 32'h0000_0010;
  localparam logic [15:0] RST_EXT_IRQ_CLEAR = 16'hc000;

  // ********************************************************
  // field positions
  // ********************************************************
  localparam int CUSTOM_LSB = 9;
  localparam int CUSTOM_NUM = 4;
  localparam int EXT_SRC_LSB = 24;
  localparam int POL_BIT = 0;
  localparam int WAKE_CFG_LSB = 0;
  localparam logic [1:0] FUNC_IRQ = 2'h1;
  localparam logic [7:0] PINS_IRQ_A = 8'h49;
  localparam logic [7:0] PINS_IRQ_B = 8'h90;

  // per-input detector field: [3] enable, [2:0] mode
  localparam logic [2:0] MODE_RISE = 3'h0;
  localparam logic [2:0] MODE_FALL = 3'h1;
  localparam logic [2:0] MODE_BOTH = 3'h2;
  localparam logic [2:0] MODE_HIGH = 3'h3;
  localparam logic [2:0] MODE_LOW = 3'h4;

  typedef struct packed {
    logic wr;
    logic rd;
    logic from_seq;
    logic [15:0] addr;
    logic [31:0] wdata;
  } icx_req_s;

  typedef struct packed {
    logic [31:0] pol;
    logic [31:0] sel_a;
    logic [31:0] sel_b;
    logic [31:0] flag_a;
    logic [31:0] flag_b;
    logic [31:0] cust;
    logic [15:0] ecfg_a;
    logic [15:0] ecfg_b;
    logic [15:0] ecfg_c;
    logic [7:0] eflag;
    logic [15:0] func;
    logic [7:0] pe;
    logic [7:0] ien;
    logic [7:0] pin_val;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] prev;
    logic [31:0] rdata;
  } icx_state_s;

endpackage : icx_pkg

// ===== hw/icx_top.sv
// icx_top: interrupt controller, external event detectors and pin glue
`timescale 1ns/10ps

// What this block does
// - two select/flag blocks share one polarity and one clear register
// - an event on an enabled source sets the block's flag bit
// - output a only on pins 0,3,6; output b only on pins 4,7
// - polarity register picks rising or falling signalling on the pin
// - an enabled interrupt changes the level of the routed pin
// - writing one to a clear bit clears that flag in both blocks
// - four custom sources at bits 12:9, raised via the trigger register
// - trigger register writes only from the sequencer; host writes ignored
// - host reads of the trigger register carry no meaningful data
// - eight external inputs, each with a configurable event mode
// - rising mode pulses on each low-to-high transition
// - falling mode pulses on each high-to-low transition
// - either-edge mode pulses on every transition
// - high mode holds the line while the input stays high
// - low mode holds the line while the input stays low
// - detection runs in hibernate and a detected event raises wake
// - general pins form one eight bit port, one bit per pin
// - pull-ups follow the pull-enable register
// - enabled input paths show pin levels in the input value register
// - with the polarity bit clear, routed pin goes high on interrupt, low again once cleared
// - writing one to an ext clear bit clears that input's flag
module icx_top (
  input wire logic clk,
  input wire logic rst,
  input wire icx_pkg::icx_req_s req,
  output logic [31:0] reg_rdata,
  input wire logic [31:0] irq_src_in,
  input wire logic hibernate,
  output logic wake,
  input wire logic [7:0] gpio_in,
  output logic [7:0] gpio_out,
  output logic [7:0] gpio_oe,
  output logic [7:0] pin_pull_up,
  output logic irq_out_a,
  output logic irq_out_b
);
  import icx_pkg::*;

  icx_state_s st;
  icx_state_s next_st;

  // ********************************************************
  // address decode
  // ********************************************************
  logic wr_hit_pol;
  logic wr_hit_clr;
  logic wr_hit_sel_a;
  logic wr_hit_sel_b;
  logic wr_hit_cust;
  logic wr_hit_eclr;
  logic [7:0] det;
  logic [31:0] src;
  logic [3:0] cust_pulse;
  logic [31:0] clr_mask;
  logic [7:0] eclr_mask;
  logic lvl_a;
  logic lvl_b;

  assign wr_hit_pol = req.wr && (req.addr == ADDR_IRQ_POLARITY);
  assign wr_hit_clr = req.wr && (req.addr == ADDR_IRQ_CLEAR);
  assign wr_hit_sel_a = req.wr && (req.addr == ADDR_IRQ_SOURCE_SELECT_A);
  assign wr_hit_sel_b = req.wr && (req.addr == ADDR_IRQ_SOURCE_SELECT_B);
  // host writes never reach the trigger register
  assign wr_hit_cust = req.wr && req.from_seq && (req.addr == ADDR_CUSTOM_IRQ_TRIGGER);
  assign wr_hit_eclr = req.wr && (req.addr == ADDR_EXT_IRQ_CLEAR);

  // ********************************************************
  // external event detectors
  // ********************************************************
  // one detector per input; sync2 and prev are both past the sync pair
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_det
      logic [3:0] cfg;
      logic cur;
      logic old;
      if (gi < 4) begin : g_a
        assign cfg = st.ecfg_a[gi*4 +: 4];
      end else begin : g_b
        assign cfg = st.ecfg_b[(gi-4)*4 +: 4];
      end
      assign cur = st.sync2[gi];
      assign old = st.prev[gi];
      always_comb begin
        det[gi] = 1'b0;
        if (cfg[3]) begin
          case (cfg[2:0])
            MODE_RISE: det[gi] = cur && !old;
            MODE_FALL: det[gi] = !cur && old;
            MODE_BOTH: det[gi] = cur ^ old;
            MODE_HIGH: det[gi] = cur;
            MODE_LOW: det[gi] = !cur;
            default: det[gi] = 1'b0;
          endcase
        end
      end
    end
  endgenerate

  // ********************************************************
  // source vector and clear masks
  // ********************************************************
  // custom events are one-cycle pulses from the sequencer write
  assign cust_pulse = wr_hit_cust ? req.wdata[3:0] : 4'h0;
  assign clr_mask = wr_hit_clr ? req.wdata : 32'h0;
  assign eclr_mask = wr_hit_eclr ? req.wdata[7:0] : 8'h0;

  // ext flags and custom pulses join the outside sources
  always_comb begin
    src = irq_src_in;
    src[EXT_SRC_LSB +: 8] = irq_src_in[EXT_SRC_LSB +: 8] | st.eflag;
    src[CUSTOM_LSB +: CUSTOM_NUM] = irq_src_in[CUSTOM_LSB +: CUSTOM_NUM] | cust_pulse;
  end

  // ********************************************************
  // next state
  // ********************************************************
  always_comb begin
    next_st = st;
    // two-stage synchroniser, then the previous-sample stage
    next_st.sync1 = gpio_in;
    next_st.sync2 = st.sync1;
    next_st.prev = st.sync2;
    // input value register follows enabled paths only
    next_st.pin_val = st.sync2 & st.ien;

    // configuration writes
    if (wr_hit_pol) begin
      next_st.pol = req.wdata;
    end
    if (wr_hit_sel_a) begin
      next_st.sel_a = req.wdata;
    end
    if (wr_hit_sel_b) begin
      next_st.sel_b = req.wdata;
    end
    if (wr_hit_cust) begin
      next_st.cust = req.wdata;
    end
    if (req.wr && req.addr == ADDR_EXT_IRQ_CONFIG_A) begin
      next_st.ecfg_a = req.wdata[15:0];
    end
    if (req.wr && req.addr == ADDR_EXT_IRQ_CONFIG_B) begin
      next_st.ecfg_b = req.wdata[15:0];
    end
    if (req.wr && req.addr == ADDR_EXT_IRQ_CONFIG_C) begin
      next_st.ecfg_c = req.wdata[15:0];
    end
    if (req.wr && req.addr == ADDR_PIN_FUNCTION) begin
      next_st.func = req.wdata[15:0];
    end
    if (req.wr && req.addr == ADDR_PIN_PULL_ENABLE) begin
      next_st.pe = req.wdata[7:0];
    end
    if (req.wr && req.addr == ADDR_PIN_INPUT_ENABLE) begin
      next_st.ien = req.wdata[7:0];
    end

    // sticky flags: set term ORed after clear so set wins
    next_st.eflag = (st.eflag & ~eclr_mask) | det;
    // one shared clear serves both blocks
    next_st.flag_a = (st.flag_a & ~clr_mask) | (src & st.sel_a);
    next_st.flag_b = (st.flag_b & ~clr_mask) | (src & st.sel_b);

    // read data, one cycle after the strobe; unmapped reads give zero
    if (req.rd) begin
      case (req.addr)
        ADDR_IRQ_POLARITY: next_st.rdata = st.pol;
        ADDR_IRQ_SOURCE_SELECT_A: next_st.rdata = st.sel_a;
        ADDR_IRQ_SOURCE_SELECT_B: next_st.rdata = st.sel_b;
        ADDR_IRQ_FLAG_A: next_st.rdata = st.flag_a;
        ADDR_IRQ_FLAG_B: next_st.rdata = st.flag_b;
        // host view of the trigger is not meaningful
        ADDR_CUSTOM_IRQ_TRIGGER: next_st.rdata = req.from_seq ? st.cust : 32'h0;
        ADDR_EXT_IRQ_CONFIG_A: next_st.rdata = {16'h0, st.ecfg_a};
        ADDR_EXT_IRQ_CONFIG_B: next_st.rdata = {16'h0, st.ecfg_b};
        ADDR_EXT_IRQ_CONFIG_C: next_st.rdata = {16'h0, st.ecfg_c};
        ADDR_EXT_IRQ_CLEAR: next_st.rdata = {16'h0, RST_EXT_IRQ_CLEAR};
        ADDR_PIN_FUNCTION: next_st.rdata = {16'h0, st.func};
        ADDR_PIN_PULL_ENABLE: next_st.rdata = {24'h0, st.pe};
        ADDR_PIN_INPUT_ENABLE: next_st.rdata = {24'h0, st.ien};
        ADDR_PIN_INPUT_VALUE: next_st.rdata = {24'h0, st.pin_val};
        default: next_st.rdata = 32'h0;
      endcase
    end
  end

  // ********************************************************
  // state register
  // ********************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.sel_a <= RST_SOURCE_SELECT;
      st.sel_b <= RST_SOURCE_SELECT;
      st.cust <= RST_CUSTOM_TRIGGER;
    end else begin
      st <= next_st;
    end
  end

  // ********************************************************
  // outputs
  // ********************************************************
  // any standing flag drives the level; polarity may invert it
  assign lvl_a = |st.flag_a;
  assign lvl_b = |st.flag_b;
  assign irq_out_a = lvl_a ^ st.pol[POL_BIT];
  assign irq_out_b = lvl_b ^ st.pol[POL_BIT];

  // wake is a level so a slow-clocked power manager cannot miss it
  assign wake = hibernate && |(st.eflag & st.ecfg_c[WAKE_CFG_LSB +: 8]);

  assign pin_pull_up = st.pe;
  assign reg_rdata = st.rdata;

  // pin routing: only the legal pins may carry each output
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      logic is_irq;
      assign is_irq = st.func[gi*2 +: 2] == FUNC_IRQ;
      always_comb begin
        gpio_out[gi] = 1'b0;
        gpio_oe[gi] = 1'b0;
        if (is_irq && PINS_IRQ_A[gi]) begin
          gpio_out[gi] = irq_out_a;
          gpio_oe[gi] = 1'b1;
        end else if (is_irq && PINS_IRQ_B[gi]) begin
          gpio_out[gi] = irq_out_b;
          gpio_oe[gi] = 1'b1;
        end
      end
    end
  endgenerate

endmodule : icx_top

// ===== verif/icx_top_assertions.sv
// icx_top_assertions: port-level checks of the interrupt controller
`timescale 1ns/10ps
module icx_top_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire icx_pkg::icx_req_s req,
  input wire logic [31:0] reg_rdata,
  input wire logic [31:0] irq_src_in,
  input wire logic hibernate,
  input wire logic wake,
  input wire logic [7:0] gpio_in,
  input wire logic [7:0] gpio_out,
  input wire logic [7:0] gpio_oe,
  input wire logic [7:0] pin_pull_up,
  input wire logic irq_out_a,
  input wire logic irq_out_b
);
  import icx_pkg::*;
  logic [31:0] sel_a;
  logic pol;
  // shadow of select a and polarity, so outputs can be tied to their causes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_a <= RST_SOURCE_SELECT;
      pol <= 1'b0;
    end else if (req.wr && req.addr == ADDR_IRQ_SOURCE_SELECT_A) begin
      sel_a <= req.wdata;
    end else if (req.wr && req.addr == ADDR_IRQ_POLARITY) begin
      pol <= req.wdata[0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_hit_a;
    (irq_src_in & sel_a) != 32'h0;
  endsequence
  sequence s_cust_a;
    req.wr && req.from_seq && req.addr == ADDR_CUSTOM_IRQ_TRIGGER
      && (req.wdata[3:0] & sel_a[12:9]) != 4'h0;
  endsequence
  property p_src_a;
    s_hit_a |=> ##[0:1] (irq_out_a != pol);
  endproperty
  a_src_a: assert property (p_src_a) else $error("irq a not raised");
  property p_cust_a;
    s_cust_a |=> ##[0:2] (irq_out_a != pol);
  endproperty
  a_cust_a: assert property (p_cust_a) else $error("custom irq lost");
  property p_oe;
    (gpio_oe & ~(PINS_IRQ_A | PINS_IRQ_B)) == 8'h0;
  endproperty
  a_oe: assert property (p_oe) else $error("irq on illegal pin");
  property p_pin_a;
    gpio_oe[0] |-> gpio_out[0] == irq_out_a;
  endproperty
  a_pin_a: assert property (p_pin_a) else $error("pin 0 not irq a");
  property p_pin_b;
    gpio_oe[4] |-> gpio_out[4] == irq_out_b;
  endproperty
  a_pin_b: assert property (p_pin_b) else $error("pin 4 not irq b");
  property p_pull;
    req.wr && req.addr == ADDR_PIN_PULL_ENABLE |=> pin_pull_up == $past(req.wdata[7:0]);
  endproperty
  a_pull: assert property (p_pull) else $error("pull-up mismatch");
  property p_rd_trig;
    req.rd && !req.from_seq && req.addr == ADDR_CUSTOM_IRQ_TRIGGER |=> reg_rdata == 32'h0;
  endproperty
  a_rd_trig: assert property (p_rd_trig) else $error("trigger read leaks");
  property p_wake;
    wake |-> hibernate;
  endproperty
  a_wake: assert property (p_wake) else $error("wake while awake");
endmodule : icx_top_assertions
bind icx_top icx_top_assertions u_chk (.clk, .rst, .req, .reg_rdata, .irq_src_in, .hibernate,
  .wake, .gpio_in, .gpio_out, .gpio_oe, .pin_pull_up, .irq_out_a, .irq_out_b);

// ===== verif/icx_host_model.sv
// icx_host_model: host side of the pins, resolves levels and counts irq a
`timescale 1ns/10ps
module icx_host_model (
  input wire logic clk,
  input wire logic [7:0] gpio_out,
  input wire logic [7:0] gpio_oe,
  input wire logic [7:0] ext_drv,
  output logic [7:0] pin,
  output logic [7:0] irq_seen
);
  logic last = 1'b0;
  logic [7:0] seen_cnt = 8'h0;
  // count kept in one process so the output has a single driver
  assign irq_seen = seen_cnt;
  // a pin the device drives shows its value, else the external source
  assign pin = (gpio_oe & gpio_out) | (~gpio_oe & ext_drv);
  // host notices an interrupt only as a rising edge on pin 0
  always @(posedge clk) begin
    last <= pin[0];
    if (pin[0] && !last) seen_cnt <= seen_cnt + 8'h1;
  end
endmodule : icx_host_model

// ===== verif/icx_top_test.sv
// icx_top_test: self-checking bench of the interrupt controller
`timescale 1ns/10ps
module icx_top_test;
  import icx_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  icx_req_s req = '0;
  logic [31:0] reg_rdata, v, irq_src_in = 32'h0;
  logic hibernate = 1'b0;
  logic wake, irq_out_a, irq_out_b, a, b;
  logic [7:0] gpio_in, gpio_out, gpio_oe, pin_pull_up, seen, ext_drv = 8'h0;
  int miscompares = 0, cmp_count = 0, cycles = 0, seed = 25351;
  icx_top u_dut (.clk, .rst, .req, .reg_rdata, .irq_src_in, .hibernate, .wake, .gpio_in,
    .gpio_out, .gpio_oe, .pin_pull_up, .irq_out_a, .irq_out_b);
  icx_host_model u_host (.clk, .gpio_out, .gpio_oe, .ext_drv, .pin(gpio_in), .irq_seen(seen));
  always #50 clk = ~clk;
  // the whole run needs about 500 cycles, so a hang is cut well above that
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] ad, input logic [31:0] d, input logic sq = 1'b0);
    @(posedge clk);
    #10 req = '{wr: 1'b1, rd: 1'b0, from_seq: sq, addr: ad, wdata: d};
    @(posedge clk);
    #10 req.wr = 1'b0;
  endtask : wr
  task automatic rc(input logic [15:0] ad, input logic [31:0] exp, input logic cmp = 1'b1);
    @(posedge clk);
    #10 req = '{wr: 1'b0, rd: 1'b1, from_seq: 1'b0, addr: ad, wdata: 32'h0};
    @(posedge clk);
    #10 req.rd = 1'b0;
    @(posedge clk);
    #10 if (cmp) chk(reg_rdata, exp);
  endtask : rc
  // level modes stay latched if active before or after the step
  function automatic logic ext_exp(input logic [2:0] m, input logic x, input logic y);
    case (m)
      MODE_RISE: return y & ~x;
      MODE_FALL: return x & ~y;
      MODE_BOTH: return x ^ y;
      MODE_HIGH: return x | y;
      default: return ~x | ~y;
    endcase
  endfunction : ext_exp
  // main sequence: reset values, routing, custom, external, pins
  initial begin
    repeat (8) @(posedge clk);
    #10 rst = 1'b0;
    rc(ADDR_IRQ_SOURCE_SELECT_B, RST_SOURCE_SELECT);
    rc(ADDR_EXT_IRQ_CLEAR, {16'h0, RST_EXT_IRQ_CLEAR});
    rc(16'h4000, 32'h0);
    wr(ADDR_PIN_FUNCTION, 32'h0101);
    chk(gpio_oe, 8'h11);
    v = 32'h1 << ($unsigned($random(seed)) % 9);
    wr(ADDR_IRQ_SOURCE_SELECT_A, v);
    wr(ADDR_IRQ_SOURCE_SELECT_B, v);
    irq_src_in = v;
    @(posedge clk);
    #10 irq_src_in = 32'h0;
    repeat (2) @(posedge clk);
    #10 chk({gpio_out[0], irq_out_a, irq_out_b}, 3'h7);
    chk(seen, 8'h1);
    rc(ADDR_IRQ_FLAG_B, v);
    wr(ADDR_IRQ_CLEAR, v);
    rc(ADDR_IRQ_FLAG_A, 32'h0);
    chk({gpio_out[0], irq_out_b}, 2'h0);
    wr(ADDR_IRQ_POLARITY, 32'h1);
    chk(irq_out_a, 1'b1);
    wr(ADDR_IRQ_POLARITY, 32'h0);
    wr(ADDR_IRQ_SOURCE_SELECT_A, 32'h1e00);
    wr(ADDR_CUSTOM_IRQ_TRIGGER, 32'hf);
    rc(ADDR_IRQ_FLAG_A, 32'h0);
    rc(ADDR_CUSTOM_IRQ_TRIGGER, 32'h0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CUSTOM_IRQ_TRIGGER, 32'h1 << i, 1'b1);
      rc(ADDR_IRQ_FLAG_A, 32'h200 << i);
      wr(ADDR_IRQ_CLEAR, 32'h200 << i);
    end
    // every mode against every step of input 1, asleep so wake can follow
    wr(ADDR_IRQ_SOURCE_SELECT_A, 32'h0200_0000);
    wr(ADDR_EXT_IRQ_CONFIG_C, 32'h2);
    hibernate = 1'b1;
    for (int m = 0; m < 5; m++) begin
      wr(ADDR_EXT_IRQ_CONFIG_A, {24'h0, 1'b1, m[2:0], 4'h0});
      for (int t = 0; t < 4; t++) begin
        a = t[1];
        b = t[0];
        @(posedge clk);
        #10 ext_drv[1] = a;
        repeat (6) @(posedge clk);
        wr(ADDR_EXT_IRQ_CLEAR, 32'h2);
        wr(ADDR_IRQ_CLEAR, 32'h0200_0000);
        ext_drv[1] = b;
        repeat (6) @(posedge clk);
        #10 chk(wake, ext_exp(m[2:0], a, b));
        rc(ADDR_IRQ_FLAG_A, {6'h0, ext_exp(m[2:0], a, b), 25'h0});
      end
    end
    hibernate = 1'b0;
    v = $random(seed);
    wr(ADDR_PIN_PULL_ENABLE, v);
    chk(pin_pull_up, v[7:0]);
    wr(ADDR_PIN_INPUT_ENABLE, v & 32'hee);
    ext_drv = v[15:8];
    repeat (4) @(posedge clk);
    rc(ADDR_PIN_INPUT_VALUE, {24'h0, v[15:8] & v[7:0] & 8'hee});
    stop_test();
  end
endmodule : icx_top_test
